// File: include/dacrc_pkg.sv
package dacrc_pkg;

  localparam int DATA_W = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CONV_CYCLES = 5'h10;
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
  localparam logic SEQ_A = 1'b0;
  localparam logic SEQ_B = 1'b1;
  localparam logic BUSY_RST = 1'b0;
  localparam logic HOLD_RST = 1'b0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic PAIR_RST = 1'b0;
  localparam int SYNC_W = 5;
  localparam logic [SYNC_W-1:0] PINS_RST = 5'h0b;

  typedef enum logic [1:0] {
    DACRC_IDLE,
    DACRC_ARMED,
    DACRC_CONVERT
  } dacrc_state_e;

  typedef struct packed {
    logic conv_clk;
    logic conversion_start_n;
    logic pair_select;
    logic chip_select_n;
    logic read_n;
  } dacrc_pins_s;

  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
  } dacrc_pair_s;

endpackage

// File: hdl/dacrc_top.sv
`timescale 1ns/1ns

module dacrc_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic conv_clk,
  input wire logic conversion_start_n,
  input wire logic pair_select,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic [dacrc_pkg::DATA_W-1:0] sar_result_a,
  input wire logic [dacrc_pkg::DATA_W-1:0] sar_result_b,
  output logic busy,
  output logic sh_hold,
  output logic [dacrc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n
);

  localparam int LAT_MAX = 2;

  dacrc_pkg::dacrc_pins_s pins_in;
  dacrc_pkg::dacrc_pins_s sync1_r;
  dacrc_pkg::dacrc_pins_s sync2_r;
  dacrc_pkg::dacrc_pins_s prev_r;

  dacrc_pkg::dacrc_state_e state_r, state_nxt;
  logic [dacrc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic hold_r, hold_nxt;
  logic pair_lat_r, pair_lat_nxt;
  logic seq_r, seq_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [dacrc_pkg::DATA_W-1:0] data_r, data_nxt;
  dacrc_pkg::dacrc_pair_s bank_r [2];
  dacrc_pkg::dacrc_pair_s bank_nxt [2];

  logic conv_fall;
  logic clk_rise;
  logic rd_fall;
  logic cs_low;
  logic pair_chg;
  logic start_edge;
  logic finish;

  assign pins_in = '{conv_clk: conv_clk, conversion_start_n: conversion_start_n,
                     pair_select: pair_select, chip_select_n: chip_select_n,
                     read_n: read_n};

  // two-stage synchroniser, then edge history
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= dacrc_pkg::PINS_RST;
      sync2_r <= dacrc_pkg::PINS_RST;
      prev_r <= dacrc_pkg::PINS_RST;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign conv_fall = prev_r.conversion_start_n && !sync2_r.conversion_start_n;
  assign clk_rise = !prev_r.conv_clk && sync2_r.conv_clk;
  assign rd_fall = prev_r.read_n && !sync2_r.read_n;
  assign cs_low = !sync2_r.chip_select_n;
  assign pair_chg = prev_r.pair_select != sync2_r.pair_select;
  assign start_edge = (state_r == dacrc_pkg::DACRC_ARMED) && clk_rise;
  assign finish = (state_r == dacrc_pkg::DACRC_CONVERT) && clk_rise
                  && (cnt_r == dacrc_pkg::CONV_CYCLES);

  // conversion sequencer, independent of read activity
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    hold_nxt = hold_r;
    pair_lat_nxt = pair_lat_r;
    bank_nxt = bank_r;
    case (state_r)
      dacrc_pkg::DACRC_IDLE: begin
        if (conv_fall) begin
          state_nxt = dacrc_pkg::DACRC_ARMED;
          busy_nxt = 1'b1;
          hold_nxt = 1'b1;
        end
      end
      dacrc_pkg::DACRC_ARMED: begin
        if (clk_rise) begin
          state_nxt = dacrc_pkg::DACRC_CONVERT;
          cnt_nxt = dacrc_pkg::CNT_FIRST;
          pair_lat_nxt = sync2_r.pair_select;
        end
      end
      dacrc_pkg::DACRC_CONVERT: begin
        if (finish) begin
          state_nxt = dacrc_pkg::DACRC_IDLE;
          cnt_nxt = dacrc_pkg::CNT_RST;
          busy_nxt = 1'b0;
          hold_nxt = 1'b0;
          bank_nxt[pair_lat_r] = '{a: sar_result_a, b: sar_result_b};
        end else if (clk_rise) begin
          cnt_nxt = cnt_r + dacrc_pkg::CNT_FIRST;
        end
      end
      default: begin
        state_nxt = dacrc_pkg::DACRC_IDLE;
      end
    endcase
    // start edges while busy fall through untouched
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= dacrc_pkg::DACRC_IDLE;
      cnt_r <= dacrc_pkg::CNT_RST;
      busy_r <= dacrc_pkg::BUSY_RST;
      hold_r <= dacrc_pkg::HOLD_RST;
      pair_lat_r <= dacrc_pkg::PAIR_RST;
      bank_r[0] <= '{a: dacrc_pkg::DATA_RST, b: dacrc_pkg::DATA_RST};
      bank_r[1] <= '{a: dacrc_pkg::DATA_RST, b: dacrc_pkg::DATA_RST};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      pair_lat_r <= pair_lat_nxt;
      bank_r <= bank_nxt;
    end
  end

  // read word is A when the sequence is at A or the pair just changed
  function automatic logic dacrc_pick_a(input logic seq, input logic chg);
    return (seq == dacrc_pkg::SEQ_A) || chg;
  endfunction

  // read port: A then B of the selected stored pair
  always_comb begin
    seq_nxt = seq_r;
    data_nxt = data_r;
    oe_n_nxt = !(cs_low && !sync2_r.read_n);
    if (!cs_low) begin
      seq_nxt = dacrc_pkg::SEQ_A;
    end else if (rd_fall) begin
      // pair change on the same edge as the strobe restarts at A
      if (dacrc_pick_a(seq_r, pair_chg)) begin
        data_nxt = bank_r[sync2_r.pair_select].a;
        seq_nxt = dacrc_pkg::SEQ_B;
      end else begin
        data_nxt = bank_r[sync2_r.pair_select].b;
        seq_nxt = dacrc_pkg::SEQ_A;
      end
    end else if (pair_chg) begin
      seq_nxt = dacrc_pkg::SEQ_A;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_r <= dacrc_pkg::SEQ_A;
      data_r <= dacrc_pkg::DATA_RST;
      oe_n_r <= dacrc_pkg::OE_N_RST;
    end else begin
      seq_r <= seq_nxt;
      data_r <= data_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign busy = busy_r;
  assign sh_hold = hold_r;
  assign data_out = data_r;
  assign data_oe_n = oe_n_r;

  property p_busy_on_start;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == dacrc_pkg::DACRC_IDLE && conv_fall) |=> busy_r && hold_r;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start)
    else $error("busy or hold missing after start edge");

  property p_hold_in_conv;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r != dacrc_pkg::DACRC_IDLE) |-> hold_r && busy;
  endproperty
  a_hold_in_conv: assert property (p_hold_in_conv)
    else $error("hold or busy low during conversion");

  property p_pair_latch;
    @(posedge core_clk) disable iff (!reset_n)
      start_edge |=> pair_lat_r == $past(sync2_r.pair_select)
                     && cnt_r == dacrc_pkg::CNT_FIRST;
  endproperty
  a_pair_latch: assert property (p_pair_latch)
    else $error("pair not latched at conversion start");

  property p_finish_len;
    @(posedge core_clk) disable iff (!reset_n)
      finish |-> cnt_r == 5'h10 ##1 !busy && state_r == dacrc_pkg::DACRC_IDLE;
  endproperty
  a_finish_len: assert property (p_finish_len)
    else $error("conversion did not end after sixteen cycles");

  property p_store;
    @(posedge core_clk) disable iff (!reset_n)
      finish |=> bank_r[pair_lat_r].a == $past(sar_result_a)
                 && bank_r[pair_lat_r].b == $past(sar_result_b);
  endproperty
  a_store: assert property (p_store)
    else $error("result not stored in latched pair");

  property p_ignore_busy;
    @(posedge core_clk) disable iff (!reset_n)
      (busy_r && conv_fall && state_r == dacrc_pkg::DACRC_CONVERT)
        |=> $stable(pair_lat_r) && state_r != dacrc_pkg::DACRC_ARMED;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("start edge disturbed running conversion");

  property p_bus_drive;
    @(posedge core_clk) disable iff (!reset_n)
      !(cs_low && !sync2_r.read_n) |=> data_oe_n;
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("bus driven without chip select and read");

  property p_bus_on;
    @(posedge core_clk) disable iff (!reset_n)
      (cs_low && !sync2_r.read_n) |-> ##[1:LAT_MAX] !data_oe_n;
  endproperty
  a_bus_on: assert property (p_bus_on)
    else $error("bus not driven during read");

  property p_a_first;
    @(posedge core_clk) disable iff (!reset_n)
      (cs_low && rd_fall && dacrc_pick_a(seq_r, pair_chg))
        |=> data_out == bank_r[$past(sync2_r.pair_select)].a && seq_r == dacrc_pkg::SEQ_B;
  endproperty
  a_a_first: assert property (p_a_first)
    else $error("first read did not give A result");

  property p_seq_reset;
    @(posedge core_clk) disable iff (!reset_n)
      (!cs_low || (pair_chg && !rd_fall)) |=> seq_r == dacrc_pkg::SEQ_A;
  endproperty
  a_seq_reset: assert property (p_seq_reset)
    else $error("read sequence not returned to A");

  property p_no_read_needed;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == dacrc_pkg::DACRC_CONVERT && clk_rise && !finish)
        |=> cnt_r == $past(cnt_r) + 5'h01;
  endproperty
  a_no_read_needed: assert property (p_no_read_needed)
    else $error("conversion count stalled");

  property p_finish_clear;
    @(posedge core_clk) disable iff (!reset_n)
      finish |=> cnt_r == dacrc_pkg::CNT_RST && !sh_hold;
  endproperty
  a_finish_clear: assert property (p_finish_clear)
    else $error("count or hold not cleared after conversion end");

  property p_busy_stays;
    @(posedge core_clk) disable iff (!reset_n)
      (busy_r && !finish) |=> busy_r;
  endproperty
  a_busy_stays: assert property (p_busy_stays)
    else $error("busy dropped before conversion end");

  property p_idle_quiet;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == dacrc_pkg::DACRC_IDLE) |-> !busy && !sh_hold;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("busy or hold high while idle");

  property p_armed_wait;
    @(posedge core_clk) disable iff (!reset_n)
      (state_r == dacrc_pkg::DACRC_ARMED && !clk_rise) |=> state_r == dacrc_pkg::DACRC_ARMED;
  endproperty
  a_armed_wait: assert property (p_armed_wait)
    else $error("conversion began without a converter clock rise");

  property p_b_second;
    @(posedge core_clk) disable iff (!reset_n)
      (cs_low && rd_fall && !pair_chg && seq_r == dacrc_pkg::SEQ_B)
        |=> data_out == bank_r[$past(sync2_r.pair_select)].b && seq_r == dacrc_pkg::SEQ_A;
  endproperty
  a_b_second: assert property (p_b_second)
    else $error("second read did not give B result");

  property p_data_stable;
    @(posedge core_clk) disable iff (!reset_n)
      !(cs_low && rd_fall) |=> $stable(data_out);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("read word changed without a read strobe");

endmodule // dacrc_top

// File: verification/dacrc_host.sv
`timescale 1ns/1ns

module dacrc_host (
  input wire logic core_clk,
  output logic conv_clk,
  output logic conversion_start_n,
  output logic pair_select,
  output logic chip_select_n,
  output logic read_n
);
  logic [1:0] ph;
  initial begin
    conv_clk = 1'b0;
    ph = 2'h0;
    conversion_start_n = 1'b1;
    pair_select = 1'b0;
    chip_select_n = 1'b1;
    read_n = 1'b1;
  end
  // free converter clock, 320 ns period
  always @(posedge core_clk) begin
    #1;
    ph = ph + 2'h1;
    if (ph == 2'h0) conv_clk = ~conv_clk;
  end
  // pair settles 400 ns ahead, held past the latch
  task automatic start_conv(input logic pair);
    pair_select = pair;
    repeat (10) @(posedge core_clk);
    #1;
    conversion_start_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    conversion_start_n = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
  endtask
  // strobes held 240 ns, no read near a start edge
  task automatic set_pins(input logic cs, input logic rd);
    chip_select_n = cs;
    read_n = rd;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
endmodule // dacrc_host

// File: verification/test_dual_adc_conversion_read_control.sv
`timescale 1ns/1ns

module test_dual_adc_conversion_read_control;
  logic core_clk, reset_n, conv_clk, conversion_start_n, pair_select;
  logic chip_select_n, read_n, busy, sh_hold, data_oe_n;
  logic [dacrc_pkg::DATA_W-1:0] sar_result_a, sar_result_b, data_out;
  int num_errors, cmp_count, cycles, busy_len;
  dacrc_host host_u (.core_clk(core_clk), .conv_clk(conv_clk),
    .conversion_start_n(conversion_start_n), .pair_select(pair_select),
    .chip_select_n(chip_select_n), .read_n(read_n));
  dacrc_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .conv_clk(conv_clk),
    .conversion_start_n(conversion_start_n), .pair_select(pair_select),
    .chip_select_n(chip_select_n), .read_n(read_n), .sar_result_a(sar_result_a),
    .sar_result_b(sar_result_b), .busy(busy), .sh_hold(sh_hold),
    .data_out(data_out), .data_oe_n(data_oe_n));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    busy_len <= busy ? busy_len + 1 : busy_len;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [11:0] exp);
    host_u.set_pins(1'b0, 1'b0);
    check({11'h0, data_oe_n}, 12'h000);
    check(data_out, exp);
    host_u.set_pins(1'b0, 1'b1);
    check({11'h0, data_oe_n}, 12'h001);
  endtask
  // conversion with a refused restart, optional reads of pair zero meanwhile
  task automatic t_conv(input logic pair, input logic [11:0] a, input logic [11:0] b,
      input logic rd_mid);
    int n;
    sar_result_a = a;
    sar_result_b = b;
    busy_len = 0;
    host_u.start_conv(pair);
    check({11'h0, sh_hold}, 12'h001);
    check({11'h0, busy}, 12'h001);
    if (rd_mid) begin
      host_u.pair_select = 1'b0;
      rd(12'h7ff);
      rd(12'h800);
      check({11'h0, busy}, 12'h001);
    end
    host_u.start_conv(pair);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({11'h0, busy_len >= 126 && busy_len <= 140}, 12'h001);
    check({11'h0, sh_hold}, 12'h000);
    sar_result_a = ~a;
    sar_result_b = ~b;
  endtask
  task automatic t_reads();
    host_u.pair_select = 1'b1;
    rd(12'h001);
    rd(12'hfff);
    rd(12'h001);
    host_u.pair_select = 1'b0;
    rd(12'h7ff);
    host_u.set_pins(1'b1, 1'b0);
    check({11'h0, data_oe_n}, 12'h001);
    host_u.set_pins(1'b1, 1'b1);
    rd(12'h7ff);
    rd(12'h800);
    host_u.set_pins(1'b1, 1'b1);
  endtask
  initial begin
    reset_n = 1'b0;
    sar_result_a = 12'h000;
    sar_result_b = 12'h000;
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    busy_len = 0;
    repeat (5) @(posedge core_clk);
    #1;
    check({busy, sh_hold, data_oe_n, 9'h000}, 12'h200);
    check(data_out, 12'h000);
    reset_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    t_conv(1'b0, 12'h7ff, 12'h800, 1'b0);
    t_conv(1'b1, 12'h001, 12'hfff, 1'b1);
    t_reads();
    conclude();
  end
endmodule // test_dual_adc_conversion_read_control
